// ===== inc/mpp_defs.svh
// constants for the multiplexed port pin block: apb offsets, field positions, resets
// assumes byte addresses on an 8-bit apb address, one 32-bit word per register
`ifndef MPP_DEFS_SVH
`define MPP_DEFS_SVH

`define MPP_NUM_PORTS      6
`define MPP_ADDR_W         8

// port n output latch / pin level at LATCH + 4n, direction at DIR + 4n
`define MPP_OFS_LATCH      8'h00
`define MPP_OFS_DIR        8'h20
`define MPP_OFS_FSEL1      8'h40
`define MPP_OFS_FSEL2      8'h44
`define MPP_OFS_FSEL3      8'h48
`define MPP_OFS_RT_CTRL    8'h4c
`define MPP_OFS_RT_BUF     8'h50
`define MPP_OFS_PULL       8'h54
`define MPP_OFS_MEM_MODE   8'h58
`define MPP_OFS_EDGE_A     8'h5c
`define MPP_OFS_EDGE_B     8'h60

// field positions
`define MPP_RT_LOW_SEL_BIT 0
`define MPP_PULL_P0_BIT    0
`define MPP_PULL_P4_BIT    1
`define MPP_PULL_P5_BIT    2
`define MPP_MM_EXT_BIT     0
`define MPP_MM_BUS16_BIT   1
`define MPP_EDGE_NMI_BIT   0

// reset values: every pin an input, no alternate function
`define MPP_RST_DIR        8'hff
`define MPP_RST_LATCH      8'h00
`define MPP_RST_ZERO       8'h00

// usable pins per port
`define MPP_MASK_4BIT      8'h0f
`define MPP_MASK_8BIT      8'hff

`endif

// ===== inc/mpp_pkg.sv
// types shared by the port pin block and whatever wires it into a chip
// assumes pad cells resolve dout/oe/pull into the real pin level
package mpp_pkg;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
    logic [7:0] pull;
  } mpp_pad_s;

  typedef struct packed {
    logic [3:0] t0;
    logic [1:0] t1;
    logic [1:0] t2;
    logic [1:0] t3;
  } mpp_timer_s;

  typedef struct packed {
    logic [1:0] txd;
    logic [1:0] sck_out;
    logic [1:0] sck_oe;
  } mpp_serial_out_s;

  typedef struct packed {
    logic [1:0] rxd;
    logic [1:0] sck_in;
  } mpp_serial_in_s;

  typedef struct packed {
    logic [15:0] ad_out;
    logic [15:0] ad_oe;
  } mpp_bus_out_s;

  typedef struct packed {
    logic       nmi;
    logic [6:0] irq;
    logic [3:0] capture;
    logic       adc_start;
    logic       tclk2;
    logic       tclk3;
  } mpp_event_s;

endpackage

// ===== rtl/mpp_ports.sv
// pin multiplexing, direction, pull-up and register logic for ports 0 to 5
// assumes an apb master on sys_clk_in and pad cells outside that merge dout/oe/pull
//
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "mpp_defs.svh"

module mpp_ports
  import mpp_pkg::*;
(
  input  wire logic                          sys_clk_in,
  input  wire logic                          reset_n_in,
  // apb slave
  input  wire logic                          psel_in,
  input  wire logic                          penable_in,
  input  wire logic                          pwrite_in,
  input  wire logic [`MPP_ADDR_W-1:0]        paddr_in,
  input  wire logic [31:0]                   pwdata_in,
  output logic      [31:0]                   prdata_out,
  output logic                               pready_out,
  output logic                               pslverr_out,
  // pads: raw pin levels in, drive/enable/pull out
  input  wire logic [`MPP_NUM_PORTS-1:0][7:0] pin_in,
  output mpp_pad_s  [`MPP_NUM_PORTS-1:0]     pad_out,
  // peripherals on the alternate functions
  input  wire logic                          rt_trigger_in,
  input  wire mpp_timer_s                    timer_in,
  input  wire mpp_serial_out_s               serial_in,
  input  wire mpp_bus_out_s                  ext_bus_in,
  output mpp_serial_in_s                     serial_out,
  output logic      [15:0]                   ext_bus_data_out,
  output mpp_event_s                         event_out
);

  localparam int NP = `MPP_NUM_PORTS;
  localparam logic [NP-1:0][7:0] WIDTH_MASK = {`MPP_MASK_8BIT, `MPP_MASK_8BIT,
    `MPP_MASK_8BIT, `MPP_MASK_8BIT, `MPP_MASK_4BIT, `MPP_MASK_4BIT};

  logic [NP-1:0][7:0] out_latch;
  logic [NP-1:0][7:0] dir;            // 1 = input
  logic [7:0]         fsel1;
  logic [7:0]         fsel2;
  logic [7:0]         fsel3;
  logic [7:0]         rt_ctrl;
  logic [3:0]         rt_buf;
  logic [3:0]         rt_stage;
  logic [2:0]         pull_ctl;
  logic [1:0]         mem_mode;
  logic [7:0]         edge_a;
  logic [7:0]         edge_b;

  logic [NP-1:0][7:0] pin_meta;
  logic [NP-1:0][7:0] pin_sync;
  logic [7:0]         p2_prev;

  logic               access;
  logic               wr_go;
  logic [31:0]        next_rdata;
  logic               next_hit;
  mpp_pad_s [NP-1:0]  next_pad;
  mpp_event_s         next_event;

  assign access = psel_in & penable_in;
  // a write lands on the edge where the master sees pready high
  assign wr_go  = access & pready_out & pwrite_in & next_hit;

  // apb: one wait state, pready and read data both come from flops
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else if (access && !pready_out) begin
      pready_out  <= 1'b1;
      pslverr_out <= ~next_hit;
      prdata_out  <= next_rdata;
    end else begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

  // decode and read mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_hit   = 1'b1;
    unique case (paddr_in)
      `MPP_OFS_FSEL1:    next_rdata[7:0] = fsel1;
      `MPP_OFS_FSEL2:    next_rdata[7:0] = fsel2;
      `MPP_OFS_FSEL3:    next_rdata[7:0] = fsel3;
      `MPP_OFS_RT_CTRL:  next_rdata[7:0] = rt_ctrl;
      `MPP_OFS_RT_BUF:   next_rdata[3:0] = rt_buf;
      `MPP_OFS_PULL:     next_rdata[2:0] = pull_ctl;
      `MPP_OFS_MEM_MODE: next_rdata[1:0] = mem_mode;
      `MPP_OFS_EDGE_A:   next_rdata[7:0] = edge_a;
      `MPP_OFS_EDGE_B:   next_rdata[7:0] = edge_b;
      default:           next_hit = 1'b0;
    endcase
    for (int p = 0; p < NP; p++) begin
      // reads see the synchronised pin, whatever owns it
      if (paddr_in == `MPP_OFS_LATCH + 8'(4 * p)) begin
        next_hit        = 1'b1;
        next_rdata[7:0] = pin_sync[p] & WIDTH_MASK[p];
      end
      if (paddr_in == `MPP_OFS_DIR + 8'(4 * p)) begin
        next_hit        = 1'b1;
        next_rdata[7:0] = dir[p] & WIDTH_MASK[p];
      end
    end
  end

  // per-port latch and direction; bits beyond a 4-bit port stay at reset
  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_port_regs
      always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          out_latch[gp] <= `MPP_RST_LATCH;   // undefined by intent; 0 keeps sims clean
          dir[gp]       <= `MPP_RST_DIR;     // every pin an input
        end else if (wr_go) begin
          // latch is written regardless of direction and held
          if (paddr_in == `MPP_OFS_LATCH + 8'(4 * gp)) begin
            out_latch[gp] <= pwdata_in[7:0] & WIDTH_MASK[gp];
          end
          if (paddr_in == `MPP_OFS_DIR + 8'(4 * gp)) begin
            dir[gp] <= pwdata_in[7:0] | ~WIDTH_MASK[gp];
          end
        end
      end
    end
  endgenerate

  // mode and function-select registers
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fsel1    <= `MPP_RST_ZERO;
      fsel2    <= `MPP_RST_ZERO;
      fsel3    <= `MPP_RST_ZERO;
      rt_ctrl  <= `MPP_RST_ZERO;
      rt_buf   <= 4'h0;
      pull_ctl <= 3'h0;
      mem_mode <= 2'h0;
      edge_a   <= `MPP_RST_ZERO;
      edge_b   <= `MPP_RST_ZERO;
    end else if (wr_go) begin
      unique case (paddr_in)
        `MPP_OFS_FSEL1:    fsel1    <= pwdata_in[7:0] & `MPP_MASK_4BIT;
        `MPP_OFS_FSEL2:    fsel2    <= pwdata_in[7:0];
        `MPP_OFS_FSEL3:    fsel3    <= pwdata_in[7:0];
        `MPP_OFS_RT_CTRL:  rt_ctrl  <= pwdata_in[7:0];
        `MPP_OFS_RT_BUF:   rt_buf   <= pwdata_in[3:0];
        `MPP_OFS_PULL:     pull_ctl <= pwdata_in[2:0];
        `MPP_OFS_MEM_MODE: mem_mode <= pwdata_in[1:0];
        `MPP_OFS_EDGE_A:   edge_a   <= pwdata_in[7:0];
        `MPP_OFS_EDGE_B:   edge_b   <= pwdata_in[7:0];
        default:           ;
      endcase
    end
  end

  // real-time output: buffer moves to the pins only on the interval trigger
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rt_stage <= 4'h0;
    end else if (rt_trigger_in) begin
      rt_stage <= rt_buf;
    end
  end

  // pins come from outside the clock domain: two flops before any use
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_meta <= '0;
      pin_sync <= '0;
      p2_prev  <= 8'h00;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
      p2_prev  <= pin_sync[2];
    end
  end

  // pad drive, enable and pull
  always_comb begin
    logic ext_en;
    logic bus16;
    ext_en = mem_mode[`MPP_MM_EXT_BIT];
    bus16  = mem_mode[`MPP_MM_BUS16_BIT];
    for (int p = 0; p < NP; p++) begin
      // port mode: direction bit 0 drives the latch
      next_pad[p].dout = out_latch[p] & WIDTH_MASK[p];
      next_pad[p].oe   = ~dir[p] & WIDTH_MASK[p];
      next_pad[p].pull = 8'h00;
    end
    // port 0 real-time output replaces the latch data
    if (rt_ctrl[`MPP_RT_LOW_SEL_BIT]) begin
      next_pad[0].dout[3:0] = rt_stage;
    end
    // port 1 timer outputs override direction
    for (int b = 0; b < 4; b++) begin
      if (fsel1[b]) begin
        next_pad[1].dout[b] = (b < 2) ? timer_in.t2[b[0]] : timer_in.t3[b[0]];
        next_pad[1].oe[b]   = 1'b1;
      end
    end
    // port 2: pin 0 never drives
    next_pad[2].oe[0] = 1'b0;
    for (int b = 1; b < 8; b++) begin
      if (fsel2[b]) begin
        // pins 1-4 carry timer 0, others have no output function
        next_pad[2].dout[b] = (b <= 4) ? timer_in.t0[b - 1] : 1'b0;
        next_pad[2].oe[b]   = (b <= 4);
      end
    end
    // port 3 alternate functions per pin
    for (int b = 0; b < 8; b++) begin
      if (fsel3[b]) begin
        unique case (b)
          0, 1: begin
            next_pad[3].dout[b] = timer_in.t1[b];
            next_pad[3].oe[b]   = 1'b1;
          end
          3, 6: begin
            next_pad[3].dout[b] = serial_in.txd[b / 6];
            next_pad[3].oe[b]   = 1'b1;
          end
          4, 7: begin
            next_pad[3].dout[b] = serial_in.sck_out[b / 7];
            next_pad[3].oe[b]   = serial_in.sck_oe[b / 7];
          end
          default: begin
            next_pad[3].dout[b] = 1'b0;      // receive pins only listen
            next_pad[3].oe[b]   = 1'b0;
          end
        endcase
      end
    end
    // external bus takes ports 4 and 5 whole
    if (ext_en) begin
      next_pad[4].dout = ext_bus_in.ad_out[7:0];
      next_pad[4].oe   = ext_bus_in.ad_oe[7:0];
      next_pad[5].dout = ext_bus_in.ad_out[15:8];
      // an 8-bit bus leaves the upper byte as a pure address output
      next_pad[5].oe   = bus16 ? ext_bus_in.ad_oe[15:8] : 8'hff;
    end
    // one enable each for ports 0, 4 and 5, applied only to pins not driving
    next_pad[0].pull = {8{pull_ctl[`MPP_PULL_P0_BIT]}} & ~next_pad[0].oe & WIDTH_MASK[0];
    next_pad[4].pull = {8{pull_ctl[`MPP_PULL_P4_BIT]}} & ~next_pad[4].oe;
    next_pad[5].pull = {8{pull_ctl[`MPP_PULL_P5_BIT]}} & ~next_pad[5].oe;
  end

  // inbound events from port 2, qualified by input port mode
  always_comb begin
    logic [7:0] in_ok;
    logic [7:0] rise;
    logic [7:0] fall;
    in_ok = dir[2] & ~fsel2;
    rise  = pin_sync[2] & ~p2_prev;
    fall  = ~pin_sync[2] & p2_prev;
    // nmi ignores any interrupt enable; edge from register a
    next_event.nmi = in_ok[0] &
      (edge_a[`MPP_EDGE_NMI_BIT] ? rise[0] : fall[0]);
    // register a enables rising, register b falling, per input
    next_event.irq = in_ok[7:1] & ((rise[7:1] & edge_a[7:1]) | (fall[7:1] & edge_b[7:1]));
    next_event.capture   = next_event.irq[3:0];
    next_event.adc_start = next_event.irq[4];
    next_event.tclk2     = in_ok[6] & pin_sync[2][6];
    next_event.tclk3     = in_ok[7] & pin_sync[2][7];
  end

  // every outward signal leaves from a flop; pads reset to high impedance
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pad_out          <= '0;
      event_out        <= '0;
      serial_out       <= '0;
      ext_bus_data_out <= 16'h0000;
    end else begin
      pad_out               <= next_pad;
      event_out             <= next_event;
      serial_out.rxd        <= {pin_sync[3][5], pin_sync[3][2]};
      serial_out.sck_in     <= {pin_sync[3][7], pin_sync[3][4]};
      ext_bus_data_out      <= {pin_sync[5], pin_sync[4]};
    end
  end

endmodule

// ===== tb/mpp_ports_sva.sv
// checker for mpp_ports, sees only its ports
// assumes one clock domain and reset_n_in async low
`timescale 1ns/10ps
module mpp_ports_sva import mpp_pkg::*; (
  input wire logic            sys_clk_in,
  input wire logic            reset_n_in,
  input wire logic            psel_in,
  input wire logic            penable_in,
  input wire logic            pready_out,
  input wire logic [5:0][7:0] pin_in,
  input wire mpp_pad_s [5:0]  pad_out,
  input wire mpp_serial_in_s  serial_out,
  input wire logic [15:0]     ext_bus_data_out,
  input wire mpp_event_s      event_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  logic [2:0] up;
  // pin paths need three settled edges after reset before $past is meaningful
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
    if (!reset_n_in) up <= 3'h0;
    else if (up != 3'h4) up <= up + 3'h1;
  AST_RST_HIZ: assert property (
    up == 3'h0 |-> {pad_out[0].oe, pad_out[1].oe, pad_out[2].oe,
    pad_out[3].oe, pad_out[4].oe, pad_out[5].oe} == 48'h0) else $error("oe after reset");
  AST_P2_IN_ONLY: assert property (!pad_out[2].oe[0]) else $error("p2 pin0 driven");
  AST_NARROW: assert property (
    {pad_out[0].oe[7:4], pad_out[1].oe[7:4]} == 8'h0) else $error("narrow port driven");
  AST_PULL_IN: assert property (
    ((pad_out[0].pull & pad_out[0].oe) | (pad_out[4].pull & pad_out[4].oe)
    | (pad_out[5].pull & pad_out[5].oe)) == 8'h0) else $error("pull on output");
  AST_PULL_PORTS: assert property (
    {pad_out[1].pull, pad_out[2].pull, pad_out[3].pull} == 24'h0) else $error("bad pull");
  AST_READY_PULSE: assert property (pready_out |=> !pready_out) else $error("long ready");
  AST_READY_WAIT: assert property (
    psel_in && !penable_in |=> !pready_out ##1 pready_out) else $error("ready late");
  AST_BUS_PINS: assert property (
    up == 3'h4 |-> ext_bus_data_out == $past({pin_in[5], pin_in[4]}, 3)) else $error("bus in");
  AST_SER_PINS: assert property (up == 3'h4 |-> serial_out ==
    $past({pin_in[3][5], pin_in[3][2], pin_in[3][7], pin_in[3][4]}, 3)) else $error("ser in");
  AST_TRIG: assert property (
    event_out.capture == event_out.irq[3:0] && event_out.adc_start == event_out.irq[4])
    else $error("trigger");
endmodule
bind mpp_ports mpp_ports_sva mpp_ports_sva_i (.*);

// ===== tb/mpp_pins.sv
// pin model: pads, outside drivers and pull-ups resolve to one level
// assumes the bench drives only pins the block leaves undriven
`timescale 1ns/10ps
module mpp_pins import mpp_pkg::*; (
  input  wire logic            clk_in,
  input  wire mpp_pad_s [5:0]  pad_in,
  input  wire logic [5:0][7:0] drv_in,
  input  wire logic [5:0][7:0] ext_oe_in,
  output logic      [5:0][7:0] pin_out
);
  logic flt = 1'b0;
  // a floating pin wanders so a stale level never passes for a match
  always @(posedge clk_in) flt <= ~flt;
  always_comb
    for (int p = 0; p < 6; p++)
      for (int b = 0; b < 8; b++)
        if (pad_in[p].oe[b]) pin_out[p][b] = pad_in[p].dout[b];
        else if (ext_oe_in[p][b]) pin_out[p][b] = drv_in[p][b];
        else if (pad_in[p].pull[b]) pin_out[p][b] = 1'b1;
        else pin_out[p][b] = flt ^ b[0];
endmodule

// ===== tb/tb_mpp_ports.sv
// bench for mpp_ports: apb master, pin model, random pins and peripherals
// assumes mpp_pins resolves the pads and the bound checker watches the ports
`timescale 1ns/10ps
module tb_mpp_ports import mpp_pkg::*; ;
  logic            clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic            trig = 1'b0, pr, pe, er;
  logic [7:0]      pa = 8'h00, m;
  logic [31:0]     pwd = 32'h0, prd, rd;
  logic [5:0][7:0] pin, la, oa, drv = '0, xoe = '1;
  logic [15:0]     bdat, bv;
  logic [23:0]     fv;
  mpp_pad_s [5:0]  pad;
  mpp_timer_s      tmr = '0;
  mpp_serial_out_s ser = '0;
  mpp_bus_out_s    bus = '0;
  mpp_serial_in_s  sin;
  mpp_event_s      ev, sv;
  int              n_mismatch = 0, n_compared = 0, cyc = 0, p, k;

  mpp_ports mpp_ports_i (.sys_clk_in(clk), .reset_n_in(rst_n), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(pr), .pslverr_out(pe), .pin_in(pin), .pad_out(pad), .rt_trigger_in(trig),
    .timer_in(tmr), .serial_in(ser), .ext_bus_in(bus), .serial_out(sin),
    .ext_bus_data_out(bdat), .event_out(ev));
  mpp_pins mpp_pins_i (.clk_in(clk), .pad_in(pad), .drv_in(drv), .ext_oe_in(xoe),
    .pin_out(pin));

  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    // no local limit: only the cycle ceiling may end this wait
    do begin
      @(posedge clk);
    end while (pr !== 1'b1);
    rd = prd;
    er = pe;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
  endtask

  function automatic logic [7:0] msk(int q);
    return (q < 2) ? 8'h0f : 8'hff;
  endfunction
  // {select mask, drive enables, drive data} of the alternate functions
  function automatic logic [23:0] fx(int q);
    if (q == 1) return {8'h0f, 8'h0f, 4'h0, tmr.t3, tmr.t2};
    if (q == 2) return {8'h1e, 8'h1e, 3'h0, tmr.t0, 1'b0};
    return {8'hff, ser.sck_oe[1], 2'b10, ser.sck_oe[0], 4'b1011, ser.sck_out[1],
      ser.txd[1], 1'b0, ser.sck_out[0], ser.txd[0], 1'b0, tmr.t1};
  endfunction

  initial begin
    k = $urandom(25302);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (p = 0; p < 6; p++) begin
      apb(1'b0, 8'h20 + 8'(4 * p), 8'h0);
      chk("dir", msk(p), rd[7:0]);
      chk("oe", 8'h0, pad[p].oe);
    end
    apb(1'b0, 8'h64, 8'h0);
    chk("err", 8'h01, {7'h0, er});
    chk("rdat", 8'h00, rd[7:0]);
    for (p = 0; p < 6; p++) begin
      la[p] = 8'($urandom);
      m = 8'($urandom);
      oa[p] = ~m & msk(p) & ((p == 2) ? 8'hfe : 8'hff);
      drv[p] <= 8'($urandom);
      xoe[p] <= ~oa[p];
      apb(1'b1, 8'(4 * p), la[p]);
      apb(1'b1, 8'h20 + 8'(4 * p), m);
      // new drive must pass the two sync flops before the read samples it
      settle();
      apb(1'b0, 8'(4 * p), 8'h0);
      chk("oe", oa[p], pad[p].oe);
      chk("dout", la[p] & oa[p], pad[p].dout & oa[p]);
      chk("pin", (la[p] & oa[p] | drv[p] & ~oa[p]) & msk(p), rd[7:0] & msk(p));
    end
    apb(1'b1, 8'h54, 8'h07);
    settle();
    for (p = 0; p < 6; p++)
      chk("pull", (p == 0 || p > 3) ? ~oa[p] & msk(p) : 8'h0, pad[p].pull);
    apb(1'b1, 8'h54, 8'h00);
    tmr <= 10'($urandom);
    ser <= 6'($urandom);
    xoe[1] <= 8'hf0;
    xoe[2] <= ~(oa[2] | 8'h1e);
    xoe[3] <= 8'h24;
    apb(1'b1, 8'h40, 8'h0f);
    apb(1'b1, 8'h44, 8'h1e);
    apb(1'b1, 8'h48, 8'hff);
    settle();
    for (p = 1; p < 4; p++) begin
      fv = fx(p);
      chk("fo", fv[15:8], pad[p].oe & fv[23:16]);
      chk("fd", fv[7:0] & fv[15:8], pad[p].dout & fv[15:8]);
    end
    bv = 16'($urandom);
    // buffer differs from the latch in every bit, so a stuck path cannot match
    bv[3:0] = ~la[0][3:0];
    xoe[0] <= 8'hf0;
    apb(1'b1, 8'h50, {4'h0, bv[3:0]});
    apb(1'b1, 8'h4c, 8'h01);
    apb(1'b1, 8'h20, 8'h00);
    @(posedge clk) trig <= 1'b1;
    @(posedge clk) trig <= 1'b0;
    settle();
    chk("rt", {4'h0, bv[3:0]}, pad[0].dout & 8'h0f);
    apb(1'b1, 8'h4c, 8'h00);
    settle();
    chk("lat", la[0] & 8'h0f, pad[0].dout & 8'h0f);
    bv = 16'($urandom);
    bus <= {16'($urandom), bv};
    xoe[4] <= ~bv[7:0];
    xoe[5] <= 8'h00;
    apb(1'b1, 8'h58, 8'h01);
    settle();
    chk("b4o", bv[7:0], pad[4].oe);
    chk("b4d", bus.ad_out[7:0] & bv[7:0], pad[4].dout & bv[7:0]);
    chk("b5o", 8'hff, pad[5].oe);
    chk("b5d", bus.ad_out[15:8], pad[5].dout);
    xoe[5] <= ~bv[15:8];
    apb(1'b1, 8'h58, 8'h03);
    settle();
    chk("b5m", bv[15:8], pad[5].oe);
    apb(1'b1, 8'h58, 8'h00);
    xoe[2] <= 8'hff;
    drv[2] <= 8'h00;
    apb(1'b1, 8'h44, 8'h00);
    apb(1'b1, 8'h28, 8'hff);
    // rising then falling under edge mode a, then the same under edge mode b
    for (k = 0; k < 4; k++) begin
      apb(1'b1, 8'h5c, (k < 2) ? 8'h23 : 8'h00);
      apb(1'b1, 8'h60, (k < 2) ? 8'h00 : 8'h22);
      repeat (6) @(posedge clk);
      sv = '0;
      drv[2] <= (k % 2 == 0) ? 8'he3 : 8'h00;
      repeat (8) begin
        @(posedge clk);
        sv = sv | ev;
      end
      chk("ev", (k == 0 || k == 3) ? 8'h91 : 8'h00, sv[14:7]);
      chk("trg", (k == 0 || k == 3) ? 8'h03 : 8'h00, 8'(sv[6:2]));
      chk("tclk", (k % 2 == 0) ? 8'h03 : 8'h00, {6'h0, ev.tclk2, ev.tclk3});
    end
    apb(1'b0, 8'h60, 8'h0);
    chk("edge_b", 8'h22, rd[7:0]);
    wrap_up();
  end
endmodule
